// >>> alpr_pkg.sv
// constants for the light persistence and residual config block
package alpr_pkg;
    localparam logic [7:0] ALPR_SRC_PERS_OFS   = 8'ha6;
    localparam logic [7:0] ALPR_RESID_OFS      = 8'ha7;
    localparam logic [7:0] ALPR_IRQ_STATUS_OFS = 8'hb8;
    localparam logic [7:0] ALPR_IRQ_MASK_OFS   = 8'hb9;
    localparam logic [7:0] ALPR_SRC_PERS_RST   = 8'h00;
    localparam logic [7:0] ALPR_RESID_RST      = 8'h03;
    localparam logic [7:0] ALPR_IRQ_MASK_RST   = 8'h00;
    localparam int ALPR_SRC_LSB      = 4;
    localparam int ALPR_PERS_LSB     = 0;
    localparam int ALPR_STARTUP_BIT  = 5;
    localparam int ALPR_FLOOR_LSB    = 2;
    localparam int ALPR_CEIL_LSB     = 0;
    localparam logic [7:0] ALPR_SRC_PERS_WMASK = 8'h3f;
    localparam logic [7:0] ALPR_RESID_WMASK    = 8'h2f;
    localparam int ALPR_IRQ_BITS     = 2;
    localparam int ALPR_IRQ_LIGHT    = 0;
    localparam int ALPR_IRQ_SAMPLE   = 1;
    localparam logic [3:0] ALPR_STARTUP_SAVED_CYC = 4'h9;
    localparam int ALPR_DATA_W       = 16;
    localparam logic [7:0] ALPR_PERS_STEP = 8'h05;
    localparam logic [7:0] ALPR_PERS_OFFS = 8'h0f;
endpackage : alpr_pkg

// >>> alpr_persist.sv
// persistence filter: counts consecutive out-of-range samples
`timescale 1ns/1ps
module alpr_persist
    import alpr_pkg::*;
(
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   resetn_i,
    // sample and config
    input  wire logic                   sample_valid_i,
    input  wire logic [ALPR_DATA_W-1:0] sample_i,
    input  wire logic [ALPR_DATA_W-1:0] low_thr_i,
    input  wire logic [ALPR_DATA_W-1:0] high_thr_i,
    input  wire logic [3:0]             persistence_i,
    // result
    output logic                        irq_event_o,
    output logic [5:0]                  count_o
);
    typedef struct packed {
        logic [5:0] count;
        logic       event_p;
    } alpr_pst_t;

    alpr_pst_t st;
    alpr_pst_t next_st;
    logic      outside;
    logic [5:0] needed;

    // codes 0..3 literal, from 4 onward 5*code-15
    function automatic logic [5:0] alpr_needed(input logic [3:0] code);
        logic [7:0] prod;
        prod = 8'h00;
        if (code < 4'h4)
        begin
            alpr_needed = {2'b00, code};
        end
        else
        begin
            prod = {4'h0, code} * ALPR_PERS_STEP - ALPR_PERS_OFFS;
            alpr_needed = prod[5:0];
        end
    endfunction : alpr_needed

    assign outside = (sample_i < low_thr_i) || (sample_i > high_thr_i);
    assign needed  = alpr_needed(persistence_i);

    always_comb
    begin
        next_st = st;
        next_st.event_p = 1'b0;
        if (sample_valid_i)
        begin
            if (!outside)
            begin
                next_st.count = 6'h00;
            end
            else if (st.count != 6'h3f)
            begin
                next_st.count = st.count + 6'h01;
            end
            if (persistence_i == 4'h0)
            begin
                next_st.event_p = 1'b1;
            end
            // widened so a saturated count still fires
            else if (outside && ({1'b0, st.count} + 7'h01 >= {1'b0, needed}))
            begin
                next_st.event_p = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign irq_event_o = st.event_p;
    assign count_o     = st.count;

    a_reset_count: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        sample_valid_i && !outside |=> count_o == 6'h00)
        else $error("count not cleared by in-range sample");
    a_every_cycle: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        sample_valid_i && persistence_i == 4'h0 |=> irq_event_o)
        else $error("no event in every-cycle mode");
    a_no_early: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        sample_valid_i && persistence_i != 4'h0
        && (!outside || {1'b0, count_o} + 7'h01 < {1'b0, needed})
        |=> !irq_event_o)
        else $error("event before persistence reached");
    a_pers_60: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        persistence_i == 4'hf |-> needed == 6'd60)
        else $error("code f must need 60 samples");
    a_out_range: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        sample_valid_i && sample_i == low_thr_i && low_thr_i <= high_thr_i
        && count_o == 6'h00 |=> count_o == 6'h00)
        else $error("threshold-equal sample counted");
endmodule : alpr_persist

// >>> alpr_top.sv
// light compare source, persistence and residual limit registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module alpr_top
    import alpr_pkg::*;
(
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   resetn_i,
    // register port
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [7:0]             reg_rdata_o,
    // modulator results and thresholds
    input  wire logic                   sample_valid_i,
    input  wire logic [ALPR_DATA_W-1:0] mod0_data_i,
    input  wire logic [ALPR_DATA_W-1:0] mod1_data_i,
    input  wire logic [ALPR_DATA_W-1:0] mod2_data_i,
    input  wire logic [ALPR_DATA_W-1:0] light_low_threshold_i,
    input  wire logic [ALPR_DATA_W-1:0] light_high_threshold_i,
    // residual request from modulator
    input  wire logic [2:0]             residual_request_i,
    // outputs
    output logic      [2:0]             residual_bits_o,
    output logic                        full_startup_per_sample_o,
    output logic      [3:0]             startup_saved_cycles_o,
    output logic      [1:0]             light_compare_source_select_o,
    output logic                        irq_o
);
    typedef struct packed {
        logic [7:0]               src_pers;
        logic [7:0]               resid;
        logic [ALPR_IRQ_BITS-1:0] status;
        logic [ALPR_IRQ_BITS-1:0] mask;
        logic [7:0]               rdata;
        logic [2:0]               resid_out;
        logic                     startup;
        logic [3:0]               saved;
        logic [1:0]               src;
        logic                     irq;
    } alpr_top_t;

    alpr_top_t st;
    alpr_top_t next_st;

    logic [ALPR_DATA_W-1:0] sel_data;
    logic                   light_event;
    logic [1:0]             src_code;
    logic [3:0]             pers_code;
    logic [2:0]             floor_bits;
    logic [2:0]             ceil_bits;
    logic [ALPR_IRQ_BITS-1:0] events;

    function automatic logic [7:0] alpr_merge(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] wmask);
        alpr_merge = (old_v & ~wmask) | (new_v & wmask);
    endfunction : alpr_merge

    assign src_code   = st.src_pers[ALPR_SRC_LSB +: 2];
    assign pers_code  = st.src_pers[ALPR_PERS_LSB +: 4];
    assign floor_bits = {1'b0, st.resid[ALPR_FLOOR_LSB +: 2]};
    assign ceil_bits  = {1'b0, st.resid[ALPR_CEIL_LSB +: 2]} + 3'h1;

    // 11 falls back to modulator 0 like 00
    always_comb
    begin
        case (src_code)
            2'b01:   sel_data = mod1_data_i;
            2'b10:   sel_data = mod2_data_i;
            default: sel_data = mod0_data_i;
        endcase
    end

    alpr_persist u_persist (
        .sys_clk_i      (sys_clk_i),
        .resetn_i       (resetn_i),
        .sample_valid_i (sample_valid_i),
        .sample_i       (sel_data),
        .low_thr_i      (light_low_threshold_i),
        .high_thr_i     (light_high_threshold_i),
        .persistence_i  (pers_code),
        .irq_event_o    (light_event),
        .count_o        ()
    );

    assign events = {sample_valid_i, light_event};

    always_comb
    begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                ALPR_SRC_PERS_OFS:
                    next_st.src_pers = alpr_merge(st.src_pers, reg_wdata_i,
                                                  ALPR_SRC_PERS_WMASK);
                ALPR_RESID_OFS:
                    next_st.resid = alpr_merge(st.resid, reg_wdata_i,
                                               ALPR_RESID_WMASK);
                ALPR_IRQ_STATUS_OFS:
                    next_st.status = st.status & ~reg_wdata_i[ALPR_IRQ_BITS-1:0];
                ALPR_IRQ_MASK_OFS:
                    next_st.mask = reg_wdata_i[ALPR_IRQ_BITS-1:0];
                default:
                    next_st.src_pers = st.src_pers;
            endcase
        end
        // set beats a clear in the same cycle
        next_st.status = next_st.status | events;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                ALPR_SRC_PERS_OFS:   next_st.rdata = st.src_pers;
                ALPR_RESID_OFS:      next_st.rdata = st.resid;
                ALPR_IRQ_STATUS_OFS: next_st.rdata = {6'h00, st.status};
                ALPR_IRQ_MASK_OFS:   next_st.rdata = {6'h00, st.mask};
                default:             next_st.rdata = 8'h00;
            endcase
        end
        // clamp request into [floor, ceiling+1]; ceiling wins if floor is above it
        next_st.resid_out = residual_request_i;
        if (residual_request_i < floor_bits)
        begin
            next_st.resid_out = floor_bits;
        end
        if (next_st.resid_out > ceil_bits)
        begin
            next_st.resid_out = ceil_bits;
        end
        next_st.startup = st.resid[ALPR_STARTUP_BIT];
        // the sequencer subtracts this from its per-sample length
        next_st.saved = st.resid[ALPR_STARTUP_BIT] ? ALPR_STARTUP_SAVED_CYC : 4'h0;
        next_st.src = src_code;
        next_st.irq = |(next_st.status & st.mask);
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st          <= '0;
            st.src_pers <= ALPR_SRC_PERS_RST;
            st.resid    <= ALPR_RESID_RST;
            st.mask     <= ALPR_IRQ_MASK_RST[ALPR_IRQ_BITS-1:0];
            st.resid_out <= 3'h0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata_o                   = st.rdata;
    assign residual_bits_o               = st.resid_out;
    assign full_startup_per_sample_o     = st.startup;
    assign startup_saved_cycles_o        = st.saved;
    assign light_compare_source_select_o = st.src;
    assign irq_o                         = st.irq;

    a_resid_floor: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        ##1 $past(floor_bits <= ceil_bits) |-> residual_bits_o >= $past(floor_bits))
        else $error("residual below floor");
    a_resid_ceiling: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        ##1 residual_bits_o <= $past(ceil_bits))
        else $error("residual above ceiling");
    a_startup_saved: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        ##1 $past(st.resid[ALPR_STARTUP_BIT]) |-> startup_saved_cycles_o == 4'h9)
        else $error("startup saving not nine cycles");
    a_src_mod2: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        src_code == 2'b10 |-> sel_data == mod2_data_i)
        else $error("source 10 not modulator 2");
    a_src_mod0: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        src_code == 2'b11 |-> sel_data == mod0_data_i)
        else $error("source 11 not modulator 0");
    a_light_sticky: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        light_event |=> st.status[ALPR_IRQ_LIGHT])
        else $error("light event lost");
    a_read_data: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == ALPR_RESID_OFS |=> reg_rdata_o == $past(st.resid))
        else $error("residual register read wrong");
endmodule : alpr_top

// >>> alpr_top_bench.sv
// self-checking bench for the light source, persistence and residual registers
`timescale 1ns/1ps
module alpr_top_bench;
    import alpr_pkg::*;
    logic                   sys_clk_i      = 1'b0;
    logic                   resetn_i       = 1'b0;
    logic [7:0]             reg_addr_i     = 8'h00;
    logic [7:0]             reg_wdata_i    = 8'h00;
    logic                   reg_wr_i       = 1'b0;
    logic                   reg_rd_i       = 1'b0;
    logic                   sample_valid_i = 1'b0;
    logic [ALPR_DATA_W-1:0] mod_d [3];
    logic [2:0]             res_req        = 3'h0;
    logic [7:0]             reg_rdata_o;
    logic [2:0]             residual_bits_o;
    logic                   full_startup_o;
    logic [3:0]             saved_o;
    logic [1:0]             src_sel_o;
    logic                   irq_o;
    logic [7:0]             exp_q [$];
    logic                   rd_d           = 1'b0;
    int                     n_mismatch     = 0;
    int                     tests_run      = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    alpr_top i_dut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .sample_valid_i(sample_valid_i), .mod0_data_i(mod_d[0]),
        .mod1_data_i(mod_d[1]), .mod2_data_i(mod_d[2]),
        .light_low_threshold_i(16'h0064), .light_high_threshold_i(16'h00c8),
        .residual_request_i(res_req), .residual_bits_o(residual_bits_o),
        .full_startup_per_sample_o(full_startup_o), .startup_saved_cycles_o(saved_o),
        .light_compare_source_select_o(src_sel_o), .irq_o(irq_o)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
        tests_run++;
        if (seen !== expv)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk_i)
    begin
        rd_d <= reg_rd_i;
        if (rd_d)
            check("read data", reg_rdata_o, exp_q.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
    endtask : rd

    // thresholds 0x64..0xc8; boundary values count as inside
    task automatic smp(input int sel, input logic o_sel, input logic o_oth);
        logic o;
        @(posedge sys_clk_i);
        for (int i = 0; i < 3; i++)
        begin
            o = (i == sel) ? o_sel : o_oth;
            mod_d[i] <= $urandom_range(1) ? (o ? 16'h00c9 : 16'h00c8)
                                          : (o ? 16'h0063 : 16'h0064);
        end
        sample_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        sample_valid_i <= 1'b0;
    endtask : smp

    task automatic stat(input logic e);
        repeat (3) @(posedge sys_clk_i);
        rd(ALPR_IRQ_STATUS_OFS, {6'h00, 1'b1, e});
        wr(ALPR_IRQ_STATUS_OFS, 8'h03);
    endtask : stat

    task automatic pers(input logic [3:0] c);
        int need;
        int sel;
        need = (c < 4) ? int'(c) : 5 * int'(c) - 15;
        sel  = (c[1:0] == 2'b11) ? 0 : int'(c[1:0]);
        wr(ALPR_SRC_PERS_OFS, {2'b00, c[1:0], c});
        smp(sel, 1'b0, 1'b1);
        check("source select", {6'h00, src_sel_o}, {6'h00, c[1:0]});
        stat(c == 4'h0);
        if (c == 4'h0)
        begin
            smp(sel, 1'b0, 1'b1);
            stat(1'b1);
        end
        else
        begin
            repeat (need - 1) smp(sel, 1'b1, 1'b0);
            smp(sel, 1'b0, 1'b1);
            repeat (need - 1) smp(sel, 1'b1, 1'b0);
            stat(1'b0);
            smp(sel, 1'b1, 1'b0);
            stat(1'b1);
        end
    endtask : pers

    initial
    begin
        logic [1:0] f;
        logic [1:0] cl;
        logic       sb;
        logic [2:0] rq;
        logic [2:0] e;
        for (int i = 0; i < 3; i++)
            mod_d[i] = 16'h0080;
        void'($urandom(32'hc239));
        repeat (12) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd(ALPR_SRC_PERS_OFS, ALPR_SRC_PERS_RST);
        rd(ALPR_RESID_OFS, 8'h03);
        rd(ALPR_IRQ_MASK_OFS, 8'h00);
        rd(8'h50, 8'h00);
        wr(8'h50, 8'hff);
        wr(ALPR_SRC_PERS_OFS, 8'hff);
        rd(ALPR_SRC_PERS_OFS, 8'h3f);
        $display("test reset and access done");
        for (int c = 0; c < 16; c++)
            pers(c[3:0]);
        $display("test persistence done");
        wr(ALPR_IRQ_MASK_OFS, 8'h01);
        pers(4'h1);
        // code 1 leaves modulator 1 selected
        smp(1, 1'b1, 1'b0);
        repeat (4) @(posedge sys_clk_i);
        check("irq set", {7'h00, irq_o}, 8'h01);
        wr(ALPR_IRQ_MASK_OFS, 8'h00);
        repeat (3) @(posedge sys_clk_i);
        check("irq masked", {7'h00, irq_o}, 8'h00);
        wr(ALPR_IRQ_MASK_OFS, 8'h01);
        wr(ALPR_IRQ_STATUS_OFS, 8'h03);
        repeat (3) @(posedge sys_clk_i);
        check("irq cleared", {7'h00, irq_o}, 8'h00);
        $display("test interrupt done");
        for (int n = 0; n < 24; n++)
        begin
            f  = 2'($urandom_range(3));
            cl = 2'($urandom_range(3));
            sb = 1'($urandom_range(1));
            rq = 3'($urandom_range(7));
            wr(ALPR_RESID_OFS, {2'b11, sb, 1'b1, f, cl});
            res_req <= rq;
            repeat (3) @(posedge sys_clk_i);
            e = (rq < {1'b0, f}) ? {1'b0, f} : rq;
            e = (e > {1'b0, cl} + 3'h1) ? {1'b0, cl} + 3'h1 : e;
            check("residual bits", {5'h00, residual_bits_o}, {5'h00, e});
            check("startup flag", {7'h00, full_startup_o}, {7'h00, sb});
            check("saved cycles", {4'h0, saved_o}, sb ? 8'h09 : 8'h00);
            rd(ALPR_RESID_OFS, {2'b00, sb, 1'b0, f, cl});
        end
        $display("test residual done");
        repeat (4) @(posedge sys_clk_i);
        close_out();
    end

    initial
    begin
        #200000;
        n_mismatch++;
        close_out();
    end
endmodule : alpr_top_bench
